// [rtl/hwm_consts.svh]
`ifndef HWM_CONSTS_SVH
`define HWM_CONSTS_SVH
// ****************************************
// register byte offsets
// ****************************************
`define HWM_OFF_OP1_FIRST   8'h00
`define HWM_OFF_OP1_LAST    8'h2C
`define HWM_OFF_OP1_WIDE    8'h10
`define HWM_OFF_OP2_16      8'h30
`define HWM_OFF_OP2_LOW     8'h34
`define HWM_OFF_OP2_HIGH    8'h38
`define HWM_OFF_RESULT_W0   8'h3C
`define HWM_OFF_RESULT_W1   8'h40
`define HWM_OFF_RESULT_W2   8'h44
`define HWM_OFF_RESULT_W3   8'h48
`define HWM_OFF_COMPAT_LOW  8'h4C
`define HWM_OFF_COMPAT_HIGH 8'h50
`define HWM_OFF_SUM_EXT     8'h54
`define HWM_OFF_CTL         8'h58
// ****************************************
// control register fields
// ****************************************
`define HWM_CTL_CARRY       0
`define HWM_CTL_FRAC        1
`define HWM_CTL_SAT         2
`define HWM_CTL_BUSY        3
// ****************************************
// byte access strobe
// ****************************************
`define HWM_STRB_BYTE       4'h1
// ****************************************
// result timing, cycles per nibble {carry,w3,w2,w1,w0}
// ****************************************
`define HWM_TM_NARROW       20'h3_4433
`define HWM_TM_WIDE_A       20'h7_7653
`define HWM_TM_WIDE_B_LOW   20'h7_7653
`define HWM_TM_WIDE_AB_LOW  20'hB_BA83
`define HWM_TM_WIDE_B_HIGH  20'h4_4430
`define HWM_TM_WIDE_AB_HIGH 20'h6_6530
`endif

// [rtl/hwm_pkg.sv]
`default_nettype none
package hwm_pkg;
    typedef enum logic [1:0] {
        HWM_UMUL = 2'b00,
        HWM_SMUL = 2'b01,
        HWM_UMAC = 2'b10,
        HWM_SMAC = 2'b11
    } hwm_mode_t;

    typedef struct packed {
        logic [3:0] c;
        logic [3:0] w3;
        logic [3:0] w2;
        logic [3:0] w1;
        logic [3:0] w0;
    } hwm_timer_t;

    typedef struct packed {
        logic        carry;
        logic [15:0] sum_extension_word;
        logic [63:0] res;
    } hwm_calc_t;
endpackage : hwm_pkg
`default_nettype wire

// [rtl/hwm_multiplier.sv]
`timescale 1ns/1ns
`default_nettype none
`include "hwm_consts.svh"
module hwm_multiplier
    import hwm_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb request
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    // apb answer
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] byte16(input logic [31:0] d,
                                           input logic byt,
                                           input logic sg);
        if (!byt)
            return d[15:0];
        return sg ? {{8{d[7]}}, d[7:0]} : {8'h00, d[7:0]};
    endfunction : byte16

    function automatic logic [31:0] ext(input logic [15:0] lo,
                                        input logic [15:0] hi,
                                        input logic wide,
                                        input logic sg);
        if (wide)
            return {hi, lo};
        return sg ? {{16{lo[15]}}, lo} : {16'h0000, lo};
    endfunction : ext

    function automatic hwm_calc_t calc(input logic [31:0] a,
                                       input logic [31:0] b,
                                       input hwm_mode_t m,
                                       input logic nar,
                                       input logic [63:0] base);
        logic [63:0] sa;
        logic [63:0] sb;
        logic [63:0] acc;
        logic [64:0] s65;
        logic [32:0] s33;
        logic        cy;
        logic        neg;
        hwm_calc_t   r;
        sa  = m[0] ? {{32{a[31]}}, a} : {32'h0000_0000, a};
        sb  = m[0] ? {{32{b[31]}}, b} : {32'h0000_0000, b};
        acc = m[1] ? base : 64'h0000_0000_0000_0000;
        s65 = {1'b0, acc} + {1'b0, 64'(sa * sb)};
        s33 = {1'b0, acc[31:0]} + {1'b0, s65[31:0] - acc[31:0]};
        r.res = s65[63:0];
        cy  = nar ? s33[32] : s65[64];
        neg = nar ? r.res[31] : r.res[63];
        case (m)
            HWM_UMUL: begin
                r.carry  = 1'b0;
                r.sum_extension_word = 16'h0000;
            end
            HWM_SMUL: begin
                r.carry  = neg;
                r.sum_extension_word = {16{neg}};
            end
            HWM_UMAC: begin
                r.carry  = cy;
                r.sum_extension_word = {15'h0000, cy};
            end
            default: begin
                r.carry  = cy;
                r.sum_extension_word = {16{neg}};
            end
        endcase
        return r;
    endfunction : calc

    function automatic hwm_timer_t tdec(input hwm_timer_t t);
        hwm_timer_t r;
        r = t;
        if (r.w0 != 4'h0) r.w0 = r.w0 - 4'h1;
        if (r.w1 != 4'h0) r.w1 = r.w1 - 4'h1;
        if (r.w2 != 4'h0) r.w2 = r.w2 - 4'h1;
        if (r.w3 != 4'h0) r.w3 = r.w3 - 4'h1;
        if (r.c  != 4'h0) r.c  = r.c  - 4'h1;
        return r;
    endfunction : tdec

    function automatic logic [4:0] tready(input hwm_timer_t t);
        return {t.c <= 4'h1, t.w3 <= 4'h1, t.w2 <= 4'h1,
                t.w1 <= 4'h1, t.w0 <= 4'h1};
    endfunction : tready

    // ****************************************
    // datapath state
    // ****************************************
    logic [15:0] op1_lo_r, op1_lo_nxt, op1_hi_r, op1_hi_nxt;
    logic [15:0] op2_lo_r, op2_lo_nxt, op2_hi_r, op2_hi_nxt;
    logic        op1_wide_r, op1_wide_nxt, need_h_r, need_h_nxt;
    logic        frac_r, frac_nxt, sat_r, sat_nxt;
    hwm_mode_t   mode_r, mode_nxt;
    logic [63:0] res_r, res_nxt, base_r, base_nxt;
    logic [15:0] sum_extension_word_r, sum_extension_word_nxt;
    logic        carry_r, carry_nxt;
    hwm_timer_t  tl_r, tl_nxt, th_r, th_nxt;
    logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [31:0] prdata_r, prdata_nxt;

    logic        wr;
    logic        byt;
    logic [5:0]  sub;
    hwm_mode_t   nm;
    logic [15:0] b16;
    logic [31:0] a32;
    logic [4:0]  rdy;
    hwm_calc_t   cr;

    assign wr  = psel && penable && pready_r && pwrite;
    assign byt = (pstrb == `HWM_STRB_BYTE);
    assign sub = paddr[7:2] - 6'(`HWM_OFF_OP1_WIDE >> 2);
    assign nm  = (paddr < `HWM_OFF_OP1_WIDE) ? hwm_mode_t'(paddr[3:2])
                                             : hwm_mode_t'(sub[2:1]);
    assign b16 = byte16(pwdata, byt, mode_r[0]);
    assign a32 = ext(op1_lo_r, op1_hi_r, op1_wide_r, mode_r[0]);
    assign rdy = tready(tl_r) & tready(th_r) & {{4{~need_h_r}}, 1'b1};

    always_comb begin
        op1_lo_nxt   = op1_lo_r;
        op1_hi_nxt   = op1_hi_r;
        op1_wide_nxt = op1_wide_r;
        op2_lo_nxt   = op2_lo_r;
        op2_hi_nxt   = op2_hi_r;
        need_h_nxt   = need_h_r;
        mode_nxt     = mode_r;
        frac_nxt     = frac_r;
        sat_nxt      = sat_r;
        res_nxt      = res_r;
        base_nxt     = base_r;
        sum_extension_word_nxt   = sum_extension_word_r;
        carry_nxt    = carry_r;
        tl_nxt       = tdec(tl_r);
        th_nxt       = tdec(th_r);
        cr           = '0;
        if (wr && paddr <= `HWM_OFF_OP1_LAST) begin
            if (paddr >= `HWM_OFF_OP1_WIDE && paddr[2]) begin
                op1_hi_nxt   = byte16(pwdata, byt, mode_r[0]);
                op1_wide_nxt = 1'b1;
            end else begin
                mode_nxt     = nm;
                op1_lo_nxt   = byte16(pwdata, byt, nm[0]);
                op1_wide_nxt = 1'b0;
            end
        end else if (wr) begin
            case (paddr)
                `HWM_OFF_OP2_16: begin
                    op2_lo_nxt = b16;
                    need_h_nxt = 1'b0;
                    cr = calc(a32, ext(b16, 16'h0000, 1'b0, mode_r[0]),
                              mode_r, !op1_wide_r, res_r);
                    res_nxt    = cr.res;
                    sum_extension_word_nxt = cr.sum_extension_word;
                    carry_nxt  = cr.carry;
                    tl_nxt = op1_wide_r ? `HWM_TM_WIDE_A
                                        : `HWM_TM_NARROW;
                    th_nxt = '0;
                end
                `HWM_OFF_OP2_LOW: begin
                    op2_lo_nxt = byte16(pwdata, byt, 1'b0);
                    need_h_nxt = 1'b1;
                    base_nxt   = res_r;
                    cr = calc(a32, {16'h0000, byte16(pwdata, byt, 1'b0)},
                              mode_r, 1'b0, res_r);
                    res_nxt    = cr.res;
                    tl_nxt = op1_wide_r ? `HWM_TM_WIDE_AB_LOW
                                        : `HWM_TM_WIDE_B_LOW;
                    th_nxt = '0;
                end
                `HWM_OFF_OP2_HIGH: begin
                    if (need_h_r) begin
                        op2_hi_nxt = b16;
                        need_h_nxt = 1'b0;
                        cr = calc(a32, {b16, op2_lo_r}, mode_r, 1'b0,
                                  base_r);
                        res_nxt    = cr.res;
                        sum_extension_word_nxt = cr.sum_extension_word;
                        carry_nxt  = cr.carry;
                        th_nxt = op1_wide_r ? `HWM_TM_WIDE_AB_HIGH
                                            : `HWM_TM_WIDE_B_HIGH;
                    end
                end
                `HWM_OFF_RESULT_W0,
                `HWM_OFF_COMPAT_LOW:  res_nxt[15:0]  = pwdata[15:0];
                `HWM_OFF_RESULT_W1,
                `HWM_OFF_COMPAT_HIGH: res_nxt[31:16] = pwdata[15:0];
                `HWM_OFF_RESULT_W2:   res_nxt[47:32] = pwdata[15:0];
                `HWM_OFF_RESULT_W3:   res_nxt[63:48] = pwdata[15:0];
                `HWM_OFF_CTL: begin
                    frac_nxt = pwdata[`HWM_CTL_FRAC];
                    sat_nxt  = pwdata[`HWM_CTL_SAT];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op1_lo_r   <= '0;
            op1_hi_r   <= '0;
            op1_wide_r <= 1'b0;
            op2_lo_r   <= '0;
            op2_hi_r   <= '0;
            need_h_r   <= 1'b0;
            mode_r     <= HWM_UMUL;
            frac_r     <= 1'b0;
            sat_r      <= 1'b0;
            res_r      <= '0;
            base_r     <= '0;
            sum_extension_word_r   <= '0;
            carry_r    <= 1'b0;
            tl_r       <= '0;
            th_r       <= '0;
        end else begin
            op1_lo_r   <= op1_lo_nxt;
            op1_hi_r   <= op1_hi_nxt;
            op1_wide_r <= op1_wide_nxt;
            op2_lo_r   <= op2_lo_nxt;
            op2_hi_r   <= op2_hi_nxt;
            need_h_r   <= need_h_nxt;
            mode_r     <= mode_nxt;
            frac_r     <= frac_nxt;
            sat_r      <= sat_nxt;
            res_r      <= res_nxt;
            base_r     <= base_nxt;
            sum_extension_word_r   <= sum_extension_word_nxt;
            carry_r    <= carry_nxt;
            tl_r       <= tl_nxt;
            th_r       <= th_nxt;
        end
    end

    // ****************************************
    // apb answer
    // ****************************************
    logic [15:0] rd;
    logic        map;
    logic        ok;

    always_comb begin
        rd  = 16'h0000;
        map = 1'b1;
        ok  = 1'b1;
        if (paddr <= `HWM_OFF_OP1_LAST) begin
            rd = (paddr >= `HWM_OFF_OP1_WIDE && paddr[2]) ? op1_hi_r
                                                          : op1_lo_r;
        end else begin
            case (paddr)
                `HWM_OFF_OP2_16,
                `HWM_OFF_OP2_LOW:     rd = op2_lo_r;
                `HWM_OFF_OP2_HIGH:    rd = op2_hi_r;
                `HWM_OFF_RESULT_W0,
                `HWM_OFF_COMPAT_LOW: begin
                    rd = res_r[15:0];
                    ok = rdy[0];
                end
                `HWM_OFF_RESULT_W1,
                `HWM_OFF_COMPAT_HIGH: begin
                    rd = res_r[31:16];
                    ok = rdy[1];
                end
                `HWM_OFF_RESULT_W2: begin
                    rd = res_r[47:32];
                    ok = rdy[2];
                end
                `HWM_OFF_RESULT_W3: begin
                    rd = res_r[63:48];
                    ok = rdy[3];
                end
                `HWM_OFF_SUM_EXT: begin
                    rd = sum_extension_word_r;
                    ok = rdy[4];
                end
                `HWM_OFF_CTL: begin
                    rd[`HWM_CTL_CARRY] = carry_r;
                    rd[`HWM_CTL_FRAC]  = frac_r;
                    rd[`HWM_CTL_SAT]   = sat_r;
                    rd[`HWM_CTL_BUSY]  = ~&rdy;
                    ok = rdy[4];
                end
                default: map = 1'b0;
            endcase
        end
        // reads of a pending word, or of the control register while carry is pending, wait; other traffic never stalls
        pready_nxt  = psel && penable && !pready_r &&
                      (pwrite || !map || ok);
        pslverr_nxt = pready_nxt && !map;
        prdata_nxt  = (pready_nxt && !pwrite) ? {16'h0000, rd}
                                              : 32'h0000_0000;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else begin
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign prdata  = prdata_r;

    // ****************************************
    // checks
    // ****************************************
    logic wr_op2, wr_second_operand_low_half, wr_second_operand_high_half;
    assign wr_op2  = wr && paddr == `HWM_OFF_OP2_16;
    assign wr_second_operand_low_half = wr && paddr == `HWM_OFF_OP2_LOW;
    assign wr_second_operand_high_half = wr && paddr == `HWM_OFF_OP2_HIGH;

    AST_NARROW_TIMING: assert property (@(posedge pclk) disable iff (!presetn)
        wr_op2 && !op1_wide_r |=> !rdy[0] ##1 !rdy[3]
            ##1 (rdy[0] && rdy[1] && rdy[4] && !rdy[2]) ##1 (rdy[2] && rdy[3]))
        else $error("narrow result timing wrong");
    AST_NARROW_THREE: assert property (@(posedge pclk) disable iff (!presetn)
        wr_op2 && !op1_wide_r |-> ##3 rdy[0])
        else $error("narrow word zero late");
    AST_WIDE_A_TIMING: assert property (@(posedge pclk) disable iff (!presetn)
        wr_op2 && op1_wide_r |-> ##4 (rdy[0] && !rdy[1]) ##1 rdy[1]
            ##1 (rdy[2] && !rdy[3]) ##1 (rdy[3] && rdy[4]))
        else $error("wide first operand timing wrong");
    AST_LOW_HALF_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
        wr_second_operand_low_half && op1_wide_r |-> ##7 (tl_r.w1 == 4'h2 && !rdy[1])
            ##1 (tl_r.w1 == 4'h1))
        else $error("low half timing wrong");
    AST_HIGH_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
        wr_second_operand_high_half && !need_h_r |=> res_r == $past(res_r)
            && th_r == tdec($past(th_r)))
        else $error("lone high half started work");
    AST_HIGH_TIMING: assert property (@(posedge pclk) disable iff (!presetn)
        wr_second_operand_high_half && need_h_r && !op1_wide_r |=> th_r.w1 == 4'h3 && !need_h_r)
        else $error("high half timing wrong");
    AST_MODE_LOW_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr >= `HWM_OFF_OP1_WIDE && paddr <= `HWM_OFF_OP1_LAST
            && paddr[2] |=> $stable(mode_r) && op1_wide_r)
        else $error("high word changed mode");
    AST_WIDTH_LAST: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr <= `HWM_OFF_OP1_LAST && !paddr[2] |=> !op1_wide_r)
        else $error("low write left operand wide");
    AST_SIGN_EXT: assert property (@(posedge pclk) disable iff (!presetn)
        wr && byt && paddr == `HWM_OFF_OP1_FIRST + 8'h04
            |=> op1_lo_r[15:8] == {8{op1_lo_r[7]}})
        else $error("byte not sign extended");
    AST_UNSIGNED_EXT: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_op2 || (wr_second_operand_high_half && need_h_r)) && mode_r == HWM_UMUL
            |=> sum_extension_word_r == 16'h0000 && !carry_r)
        else $error("unsigned sum extension nonzero");
endmodule : hwm_multiplier
`default_nettype wire

// [bench/hwm_core_model.sv]
`timescale 1ns/1ns
`default_nettype none
module hwm_core_model (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb,
    // apb answer
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
        pstrb   = 4'h0;
    end
    // ****
    // one transfer, entered right after an edge
    // ****
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] rd, output logic err,
                        output int cyc);
        cyc = 1;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // reads and writes alike; a stalled answer is simply waited out
        do begin
            @(posedge pclk);
            cyc++;
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
    endtask : xfer
    // released address and data lines show the inverse, not the old value
    task automatic idle;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~paddr;
        pwdata  <= ~pwdata;
        @(posedge pclk);
    endtask : idle
endmodule : hwm_core_model
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "hwm_consts.svh"
module tb;
    import hwm_pkg::*;
    // ****
    // bench state
    // ****
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, errv;
    logic [7:0]  paddr;
    logic [3:0]  pstrb;
    logic [31:0] pwdata, prdata, lfsr_r, rdv;
    logic [63:0] prev;
    int          cyc, t4, wb, ticks, bad_count, tests_run;

    hwm_core_model hwm_core_model_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    hwm_multiplier hwm_multiplier_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // ****
    // expectations and bus helpers
    // ****
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next
    function automatic logic [63:0] prod(input logic [31:0] a,
                                         input logic [31:0] b, input logic sg);
        logic [63:0] ea;
        logic [63:0] eb;
        ea = {{32{a[31] & sg}}, a};
        eb = {{32{b[31] & sg}}, b};
        return ea * eb;
    endfunction : prod
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
                      input logic [3:0] s = 4'hf);
        hwm_core_model_inst.xfer(1'b1, a, {16'h0000, d}, s, rdv, errv, cyc);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        hwm_core_model_inst.xfer(1'b0, a, 32'h0000_0000, 4'h0, rdv, errv, cyc);
    endtask : rd
    task automatic chk_res(input logic [63:0] e);
        logic [63:0] got;
        for (int i = 0; i < 4; i++) begin
            rd(8'(`HWM_OFF_RESULT_W0 + 4 * i));
            got[16*i +: 16] = rdv[15:0];
        end
        check(got, e);
    endtask : chk_res
    task automatic narrow(input logic [1:0] m, input logic [15:0] a,
                          input logic [15:0] b);
        logic [63:0] p;
        logic [32:0] s;
        logic [15:0] lo;
        p = prod({{16{a[15] & m[0]}}, a}, {{16{b[15] & m[0]}}, b}, m[0]);
        s = m[1] ? {1'b0, prev[31:0]} + {1'b0, p[31:0]}
                 : {m[0] & p[31], p[31:0]};
        wr(8'(4 * m), a);
        wr(`HWM_OFF_OP2_16, b);
        rd(`HWM_OFF_COMPAT_LOW);
        lo = rdv[15:0];
        rd(`HWM_OFF_COMPAT_HIGH);
        check(64'({rdv[15:0], lo}), 64'(s[31:0]));
        rd(`HWM_OFF_SUM_EXT);
        check(64'(rdv), m[0] ? 64'({16{s[31]}}) : 64'(s[32]));
        rd(`HWM_OFF_CTL);
        if (m != 2'b11) check(64'(rdv[0]), 64'(s[32]));
        if (!m[1]) chk_res(p);
        prev = m[1] ? 64'(s[31:0]) : p;
    endtask : narrow
    task automatic wide(input logic sg, input logic [31:0] a,
                        input logic [31:0] b);
        wr(8'(`HWM_OFF_OP1_WIDE + 8 * sg), a[15:0]);
        wr(8'(`HWM_OFF_OP1_WIDE + 8 * sg + 4), a[31:16]);
        wr(`HWM_OFF_OP2_LOW, b[15:0]);
        wr(`HWM_OFF_OP2_HIGH, b[31:16]);
        chk_res(prod(a, b, sg));
    endtask : wide
    task automatic end_of_test;
        $display("compared %0d, mismatched %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test
    // ****
    // hang guard
    // ****
    always @(posedge pclk) begin
        ticks <= ticks + 1;
        if (ticks > 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    // ****
    // main sequence
    // ****
    initial begin
        presetn = 1'b0;
        ticks = 0;
        bad_count = 0;
        tests_run = 0;
        lfsr_r = 32'h0000_0006;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        narrow(2'h0, 16'hffff, 16'hffff);
        for (int i = 0; i < 24; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            narrow(2'(i), lfsr_r[15:0], lfsr_r[31:16]);
        end
        $display("done narrow modes");
        wide(1'b1, 32'h8000_0000, 32'h7fff_ffff);
        for (int i = 0; i < 8; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            wide(1'(i), lfsr_r, lfsr_next(lfsr_r));
        end
        $display("done wide operands");
        wr(8'h04, 16'h0080, `HWM_STRB_BYTE);
        wr(`HWM_OFF_OP2_16, 16'h0003);
        chk_res(64'hffff_ffff_ffff_fe80);
        wr(8'h14, 16'h1234);
        wr(8'h10, 16'h0005);
        wr(`HWM_OFF_OP2_16, 16'h0007);
        chk_res(64'h23);
        wr(`HWM_OFF_OP2_HIGH, 16'h00ff);
        chk_res(64'h23);
        $display("done byte, order and lone high half");
        wr(8'h00, 16'h0003);
        wr(`HWM_OFF_OP2_16, 16'h0005);
        rd(`HWM_OFF_RESULT_W2);
        t4 = cyc;
        wr(`HWM_OFF_OP2_16, 16'h0005);
        rd(`HWM_OFF_RESULT_W0);
        check(64'(t4 - cyc), 64'h1);
        wr(8'h10, 16'h0003);
        wr(8'h14, 16'h0001);
        wr(`HWM_OFF_OP2_16, 16'h0005);
        rd(`HWM_OFF_RESULT_W3);
        check(64'(cyc - t4), 64'h3);
        wr(`HWM_OFF_OP2_LOW, 16'h0002);
        wr(`HWM_OFF_OP2_HIGH, 16'h0001);
        wb = cyc;
        rd(`HWM_OFF_RESULT_W3);
        check(64'(wb), 64'h3);
        check(64'(cyc - t4), 64'((11 - wb > 6 ? 11 - wb : 6) - 4));
        wr(8'h00, 16'h0003);
        wr(`HWM_OFF_OP2_LOW, 16'h0002);
        wr(`HWM_OFF_OP2_HIGH, 16'h0001);
        rd(`HWM_OFF_RESULT_W3);
        check(64'(cyc - t4), 64'((7 - wb > 4 ? 7 - wb : 4) - 4));
        $display("done result timing");
        wr(`HWM_OFF_CTL, 16'h0006);
        rd(`HWM_OFF_CTL);
        check(64'(rdv[2:1]), 64'h3);
        rd(8'h5c);
        check(64'({errv, rdv}), 64'h1_0000_0000);
        wr(`HWM_OFF_OP2_LOW, 16'h1111);
        hwm_core_model_inst.idle();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_res(64'h0);
        rd(`HWM_OFF_CTL);
        check(64'(rdv), 64'h0);
        $display("done unmapped and reset");
        end_of_test();
    end
endmodule : tb
`default_nettype wire
